// ==== hw/fobe_pkg.sv ====
// constants, carriers and state layouts shared by the overlay and boot entry block
// assumes a 50 MHz system clock and a 32-bit classic wishbone register port
package fobe_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_OVERLAY = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_PERIOD = 8'h08;
   // overlay select fields and value after reset
   localparam logic [15:0] OVERLAY_RESET = 16'h0000;
   localparam int EMU_SEL_BIT = 2;
   localparam int AREA_HI_BIT = 1;
   localparam int AREA_LO_BIT = 0;
   // address map of the overlay
   localparam logic [9:0] FLASH_EMU_TOP = 10'h001;
   localparam logic [13:0] RAM_WIN_TOP = 14'h3ffe;
   localparam logic [1:0] KB_IN_BLOCK_FIRST = 2'h0;
   // mode pin codes, ordered {write permit, md3, md2, md1, md0}
   localparam logic [4:0] BOOT_CODE = 5'h00;
   localparam logic [4:0] USER_PROG_CODE = 5'h02;
   localparam logic [1:0] START_WAIT = 2'h3;
   // bit rate measurement and loader
   localparam int BAUD_W = 17;
   localparam logic [16:0] BITS_IN_SPAN = 17'h00009;
   localparam logic [16:0] SPAN_ROUND = 17'h00004;
   localparam logic [16:0] MIN_PERIOD = 17'h00004;
   localparam logic [7:0] ACK_BYTE = 8'h00;
   localparam logic [7:0] KEY_BYTE = 8'h55;
   localparam logic [7:0] FILL_BYTE = 8'h00;
   localparam logic [23:0] PROG_AREA_BASE = 24'hffe000;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } fobe_wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } fobe_wb_rsp_t;

   typedef struct packed {
      logic req;
      logic we;
      logic [23:0] addr;
   } fobe_mem_req_t;

   typedef struct packed {
      logic rxd;
      logic flash_write_permit_pin;
      logic mode_pin_3;
      logic mode_pin_2;
      logic mode_pin_1;
      logic mode_pin_0;
   } fobe_pins_t;

   typedef enum logic [3:0] {
      BT_OFF, BT_HUNT, BT_MEASURE, BT_ACK, BT_WAIT_KEY,
      BT_LEN_HI, BT_LEN_LO, BT_LOAD, BT_BRANCH, BT_DONE, BT_FAIL
   } fobe_boot_t;

   typedef enum logic [1:0] {
      SR_IDLE, SR_START, SR_DATA, SR_STOP
   } fobe_ser_t;
endpackage

// ==== hw/fobe_ser_rx.sv ====
// serial receiver for the boot link: 8 data bits, 1 stop bit, no parity
// assumes rxd is already synchronised to clk and period is stable while enabled
`timescale 1ns/1ps
module fobe_ser_rx (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic en,
   // line and rate
   input wire logic rxd,
   input wire logic [fobe_pkg::BAUD_W-1:0] period,
   // received byte
   output logic valid,
   output logic [7:0] data
);
   import fobe_pkg::*;
   typedef struct packed {
      fobe_ser_t state;
      logic [BAUD_W-1:0] cnt;
      logic [2:0] bitn;
      logic [7:0] shift;
      logic valid;
   } fobe_rx_st_t;
   fobe_rx_st_t st_ff, nxt_st;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.valid = 1'b0;
      if (st_ff.cnt != '0) begin
         nxt_st.cnt = st_ff.cnt - 1'b1;
      end
      case (st_ff.state)
         SR_IDLE: begin
            if (en && !rxd) begin
               nxt_st.state = SR_START;
               nxt_st.cnt = period >> 1;
            end
         end
         SR_START: begin
            if (st_ff.cnt == '0) begin
               // a glitch shorter than half a bit is dropped here
               nxt_st.state = rxd ? SR_IDLE : SR_DATA;
               nxt_st.cnt = period;
               nxt_st.bitn = 3'h0;
            end
         end
         SR_DATA: begin
            if (st_ff.cnt == '0) begin
               nxt_st.shift = {rxd, st_ff.shift[7:1]};
               nxt_st.cnt = period;
               nxt_st.bitn = st_ff.bitn + 1'b1;
               if (st_ff.bitn == 3'h7) begin
                  nxt_st.state = SR_STOP;
               end
            end
         end
         SR_STOP: begin
            if (st_ff.cnt == '0) begin
               nxt_st.state = SR_IDLE;
               nxt_st.valid = rxd;
            end
         end
         default: nxt_st.state = SR_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign valid = st_ff.valid;
   assign data = st_ff.shift;
endmodule

// ==== hw/fobe_ser_tx.sv ====
// serial transmitter for the boot link: start, 8 data bits lsb first, 1 stop bit
// assumes start is a one-cycle pulse given only while busy is low
`timescale 1ns/1ps
module fobe_ser_tx (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // request
   input wire logic start,
   input wire logic [7:0] data,
   input wire logic [fobe_pkg::BAUD_W-1:0] period,
   // line and status
   output logic txd,
   output logic busy,
   output logic done
);
   import fobe_pkg::*;
   typedef struct packed {
      logic busy;
      logic done;
      logic txd_n;
      logic [BAUD_W-1:0] cnt;
      logic [3:0] bitn;
      logic [8:0] shift;
   } fobe_tx_st_t;
   fobe_tx_st_t st_ff, nxt_st;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.done = 1'b0;
      if (!st_ff.busy) begin
         if (start) begin
            nxt_st.busy = 1'b1;
            nxt_st.txd_n = 1'b1;
            nxt_st.shift = {1'b1, data};
            nxt_st.cnt = period;
            nxt_st.bitn = 4'h0;
         end
      end else if (st_ff.cnt != '0) begin
         nxt_st.cnt = st_ff.cnt - 1'b1;
      end else begin
         nxt_st.cnt = period;
         nxt_st.txd_n = ~st_ff.shift[0];
         nxt_st.shift = {1'b1, st_ff.shift[8:1]};
         nxt_st.bitn = st_ff.bitn + 1'b1;
         if (st_ff.bitn == 4'h9) begin
            nxt_st.busy = 1'b0;
            nxt_st.done = 1'b1;
            nxt_st.txd_n = 1'b0;
         end
      end
   end

   // line idles high; stored inverted so reset to zero gives a high line
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign txd = ~st_ff.txd_n;
   assign busy = st_ff.busy;
   assign done = st_ff.done;
endmodule

// ==== hw/fobe_top.sv ====
// flash ram overlay, programming mode entry and boot loader with bit rate detection
// assumes same-clock bus inputs and asynchronous mode and serial pins
// How it works
// - overlay select cleared by power-on reset only
// - reserved bits 15..3 read zero, written zero
// - emulation select enables overlay, locks program/erase
// - only first kilobyte of block is overlaid
// - area bits pick block four to seven
// - programming state only from pins at reset
// - decode boot and user program pin codes
// - boot mode uses serial channel one, async
// - loader stores received bytes into ram, in order
// - branch to program area start when loaded
// - measure low time of zero bytes for rate
// - frames are 8 data, 1 stop, no parity
// - send one zero byte after rate computed
// - rate detection valid within clock ranges
`timescale 1ns/1ps
module fobe_top (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic standby,
   // register bus
   input wire fobe_pkg::fobe_wb_req_t wb_req,
   output fobe_pkg::fobe_wb_rsp_t wb_rsp,
   // pins
   input wire fobe_pkg::fobe_pins_t pins,
   output logic txd,
   // cpu memory path
   input wire fobe_pkg::fobe_mem_req_t cpu_req,
   output fobe_pkg::fobe_mem_req_t mem_req,
   output logic mem_to_ram,
   // flash control
   output logic flash_pe_lock,
   output logic flash_pe_permit,
   output logic boot_mode,
   output logic user_prog_mode,
   // loader ram port and branch
   output logic ram_we,
   output logic [23:0] ram_addr,
   output logic [7:0] ram_data,
   output logic branch,
   output logic [23:0] branch_addr
);
   import fobe_pkg::*;

   typedef struct packed {
      fobe_pins_t pin_s1;
      fobe_pins_t pin_s2;
      logic rx_prev;
      logic [1:0] start_cnt;
      logic mode_valid;
      logic boot;
      logic user;
      logic [2:0] overlay;
      logic ack;
      logic [31:0] rdat;
      fobe_mem_req_t map;
      logic map_ram;
      logic pe_lock;
      logic pe_permit;
      fobe_boot_t bstate;
      logic [BAUD_W-1:0] meas_cnt;
      logic [BAUD_W-1:0] bit_period;
      logic tx_start;
      logic [15:0] len;
      logic [15:0] load_cnt;
      logic ram_we;
      logic [23:0] ram_addr;
      logic [7:0] ram_data;
      logic branch;
      logic [23:0] branch_addr;
   } fobe_top_st_t;

   fobe_top_st_t st_ff, nxt_st;
   logic rx_now;
   logic rx_en;
   logic rx_valid;
   logic [7:0] rx_data;
   logic tx_txd;
   logic tx_busy;
   logic tx_done;
   logic wb_hit;
   logic ovl_hit;
   logic [BAUD_W-1:0] period_calc;
   logic [4:0] mode_code;
   logic [31:0] status_word;

   // the line is read only after two stages
   assign rx_now = st_ff.pin_s2.rxd;
   assign mode_code = {st_ff.pin_s2.flash_write_permit_pin, st_ff.pin_s2.mode_pin_3,
                       st_ff.pin_s2.mode_pin_2, st_ff.pin_s2.mode_pin_1, st_ff.pin_s2.mode_pin_0};
   assign rx_en = (st_ff.bstate == BT_WAIT_KEY) || (st_ff.bstate == BT_LEN_HI) ||
                  (st_ff.bstate == BT_LEN_LO) || (st_ff.bstate == BT_LOAD);
   assign wb_hit = wb_req.cyc && wb_req.stb;
   // rounding keeps the error under half a cycle per bit over the nine-bit span
   assign period_calc = BAUD_W'((st_ff.meas_cnt + SPAN_ROUND) / BITS_IN_SPAN);
   assign ovl_hit = st_ff.overlay[EMU_SEL_BIT] &&
                    (cpu_req.addr[23:14] == FLASH_EMU_TOP) &&
                    (cpu_req.addr[13:12] == {st_ff.overlay[AREA_HI_BIT], st_ff.overlay[AREA_LO_BIT]}) &&
                    (cpu_req.addr[11:10] == KB_IN_BLOCK_FIRST);
   assign status_word = {st_ff.load_cnt, 4'h0, st_ff.bstate, 2'h0, st_ff.bstate == BT_FAIL,
                         st_ff.bstate == BT_DONE, st_ff.pe_permit, st_ff.user, st_ff.boot, st_ff.mode_valid};

   always_comb begin
      nxt_st = st_ff;
      nxt_st.ack = 1'b0;
      nxt_st.tx_start = 1'b0;
      nxt_st.ram_we = 1'b0;
      nxt_st.branch = 1'b0;

      // pin synchronisers
      nxt_st.pin_s1 = pins;
      nxt_st.pin_s2 = st_ff.pin_s1;
      nxt_st.rx_prev = rx_now;

      // pins are caught once, a few cycles after reset release
      if (!st_ff.mode_valid) begin
         if (st_ff.start_cnt == START_WAIT) begin
            nxt_st.mode_valid = 1'b1;
            nxt_st.boot = (mode_code == BOOT_CODE);
            nxt_st.user = (mode_code == USER_PROG_CODE);
         end else begin
            nxt_st.start_cnt = st_ff.start_cnt + 1'b1;
         end
      end

      // register bus: ack one cycle after the request, write at the acked edge
      if (wb_hit && !st_ff.ack) begin
         nxt_st.ack = 1'b1;
         case (wb_req.adr)
            OFS_OVERLAY: nxt_st.rdat = {16'h0000, 13'h0000, st_ff.overlay};
            OFS_STATUS: nxt_st.rdat = status_word;
            OFS_PERIOD: nxt_st.rdat = {15'h0000, st_ff.bit_period};
            default: nxt_st.rdat = 32'h0000_0000;
         endcase
      end
      // standby does not touch this register; only reset clears it
      if (st_ff.ack && wb_hit && wb_req.we && (wb_req.adr == OFS_OVERLAY) && wb_req.sel[0]) begin
         nxt_st.overlay = wb_req.dat[2:0];
      end

      // address steering, both directions alike
      nxt_st.map.req = cpu_req.req;
      nxt_st.map.we = cpu_req.we;
      nxt_st.map.addr = ovl_hit ? {RAM_WIN_TOP, cpu_req.addr[9:0]} : cpu_req.addr;
      nxt_st.map_ram = ovl_hit || (cpu_req.addr[23:10] == RAM_WIN_TOP);
      nxt_st.pe_lock = st_ff.overlay[EMU_SEL_BIT];
      nxt_st.pe_permit = st_ff.mode_valid && (st_ff.boot || st_ff.user) && !st_ff.overlay[EMU_SEL_BIT];

      // boot loader over serial channel one
      case (st_ff.bstate)
         BT_OFF: begin
            if (st_ff.mode_valid && st_ff.boot) begin
               nxt_st.bstate = BT_HUNT;
            end
         end
         BT_HUNT: begin
            if (st_ff.rx_prev && !rx_now) begin
               nxt_st.bstate = BT_MEASURE;
               nxt_st.meas_cnt = {{(BAUD_W-1){1'b0}}, 1'b1};
            end
         end
         BT_MEASURE: begin
            if (!rx_now) begin
               if (st_ff.meas_cnt != {BAUD_W{1'b1}}) begin
                  nxt_st.meas_cnt = st_ff.meas_cnt + 1'b1;
               end
            end else if (period_calc < MIN_PERIOD) begin
               // too short for a real frame at a supported rate; treat as noise
               nxt_st.bstate = BT_HUNT;
            end else begin
               nxt_st.bit_period = period_calc;
               nxt_st.tx_start = 1'b1;
               nxt_st.bstate = BT_ACK;
            end
         end
         BT_ACK: begin
            if (tx_done) begin
               nxt_st.bstate = BT_WAIT_KEY;
            end
         end
         BT_WAIT_KEY: begin
            if (rx_valid) begin
               if (rx_data == KEY_BYTE) begin
                  nxt_st.bstate = BT_LEN_HI;
               end else if (rx_data != FILL_BYTE) begin
                  // only a power-on reset leaves this state
                  nxt_st.bstate = BT_FAIL;
               end
            end
         end
         BT_LEN_HI: begin
            if (rx_valid) begin
               nxt_st.len = {rx_data, 8'h00};
               nxt_st.bstate = BT_LEN_LO;
            end
         end
         BT_LEN_LO: begin
            if (rx_valid) begin
               nxt_st.len = {st_ff.len[15:8], rx_data};
               nxt_st.load_cnt = 16'h0000;
               nxt_st.bstate = ({st_ff.len[15:8], rx_data} == 16'h0000) ? BT_BRANCH : BT_LOAD;
            end
         end
         BT_LOAD: begin
            if (rx_valid) begin
               nxt_st.ram_we = 1'b1;
               nxt_st.ram_addr = PROG_AREA_BASE + {8'h00, st_ff.load_cnt};
               nxt_st.ram_data = rx_data;
               nxt_st.load_cnt = st_ff.load_cnt + 1'b1;
               if (st_ff.load_cnt + 1'b1 == st_ff.len) begin
                  nxt_st.bstate = BT_BRANCH;
               end
            end
         end
         BT_BRANCH: begin
            nxt_st.branch = 1'b1;
            nxt_st.branch_addr = PROG_AREA_BASE;
            nxt_st.bstate = BT_DONE;
         end
         BT_DONE: nxt_st.bstate = BT_DONE;
         BT_FAIL: nxt_st.bstate = BT_FAIL;
         default: nxt_st.bstate = BT_OFF;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   fobe_ser_rx u_rx (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .en(rx_en),
      .rxd(rx_now),
      .period(st_ff.bit_period),
      .valid(rx_valid),
      .data(rx_data)
   );

   fobe_ser_tx u_tx (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .start(st_ff.tx_start),
      .data(ACK_BYTE),
      .period(st_ff.bit_period),
      .txd(tx_txd),
      .busy(tx_busy),
      .done(tx_done)
   );

   assign txd = tx_txd;
   assign wb_rsp.ack = st_ff.ack;
   assign wb_rsp.dat = st_ff.rdat;
   assign mem_req = st_ff.map;
   assign mem_to_ram = st_ff.map_ram;
   assign flash_pe_lock = st_ff.pe_lock;
   assign flash_pe_permit = st_ff.pe_permit;
   assign boot_mode = st_ff.boot;
   assign user_prog_mode = st_ff.user;
   assign ram_we = st_ff.ram_we;
   assign ram_addr = st_ff.ram_addr;
   assign ram_data = st_ff.ram_data;
   assign branch = st_ff.branch;
   assign branch_addr = st_ff.branch_addr;

   // standby needs no action: nothing here is cleared by it
   logic unused_inputs;
   assign unused_inputs = standby ^ tx_busy;
endmodule

// ==== testbench/fobe_monitor.sv ====
// concurrent checks on the overlay, mode entry and boot loader ports
// assumes it is bound into fobe_top with one clock domain; a request counts only on an enabled edge
`timescale 1ns/1ps
module fobe_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // register bus
   input wire fobe_pkg::fobe_wb_req_t wb_req,
   input wire fobe_pkg::fobe_wb_rsp_t wb_rsp,
   // memory path
   input wire fobe_pkg::fobe_mem_req_t cpu_req,
   input wire fobe_pkg::fobe_mem_req_t mem_req,
   input wire logic mem_to_ram,
   // mode and loader outputs
   input wire logic txd,
   input wire logic flash_pe_lock,
   input wire logic flash_pe_permit,
   input wire logic boot_mode,
   input wire logic user_prog_mode,
   input wire logic ram_we,
   input wire logic branch,
   input wire logic [23:0] branch_addr
);
   import fobe_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_take;
      ce && wb_req.cyc && wb_req.stb && !wb_rsp.ack;
   endsequence
   sequence s_ov_wr;
      s_take ##0 wb_req.we && wb_req.adr == OFS_OVERLAY && wb_req.sel[0];
   endsequence
   // ack pulse tied to the request edge
   AST_ACK_NEXT: assert property (s_take |=> wb_rsp.ack ##1 !wb_rsp.ack)
      else $error("bus ack not a one cycle pulse after request");
   AST_RSV_ZERO: assert property (s_take ##0 !wb_req.we && wb_req.adr == OFS_OVERLAY |=> wb_rsp.dat[31:3] == 29'h0)
      else $error("reserved overlay bits read non zero");
   AST_LOCK_FOLLOWS: assert property (s_ov_wr |-> ##3 flash_pe_lock == $past(wb_req.dat[EMU_SEL_BIT], 3))
      else $error("program erase lock does not follow emulation select");
   AST_PERMIT_EXCL: assert property (flash_pe_lock && $past(flash_pe_lock) |-> !flash_pe_permit)
      else $error("program erase permitted while emulation selected");
   AST_MODES_EXCL: assert property (!(boot_mode && user_prog_mode))
      else $error("both programming modes decoded");
   AST_BOOT_HOLD: assert property (boot_mode |=> $stable(boot_mode) && $stable(user_prog_mode))
      else $error("programming mode changed outside reset");
   // offset bits and direction pass untouched whether overlaid or not
   AST_PASS_THRU: assert property (mem_req.req == $past(cpu_req.req) && mem_req.we == $past(cpu_req.we)
      && mem_req.addr[9:0] == $past(cpu_req.addr[9:0]))
      else $error("memory request not a one cycle copy");
   AST_NO_EMU: assert property (!flash_pe_lock |-> mem_req.addr == $past(cpu_req.addr))
      else $error("address translated with emulation off");
   AST_RAM_WIN: assert property (mem_to_ram |-> mem_req.addr[23:10] == RAM_WIN_TOP)
      else $error("ram flag outside ram window");
   AST_BRANCH: assert property (branch |-> branch_addr == PROG_AREA_BASE ##1 !branch)
      else $error("branch pulse or target wrong");
   AST_LOAD_BOOT: assert property (ram_we |-> boot_mode)
      else $error("loader write outside boot mode");
   AST_TXD_IDLE: assert property (!boot_mode |-> txd)
      else $error("serial line active outside boot mode");
endmodule
bind fobe_top fobe_monitor mon_u (.clk(clk), .rst(rst), .ce(ce), .wb_req(wb_req), .wb_rsp(wb_rsp),
   .cpu_req(cpu_req), .mem_req(mem_req), .mem_to_ram(mem_to_ram), .txd(txd),
   .flash_pe_lock(flash_pe_lock), .flash_pe_permit(flash_pe_permit), .boot_mode(boot_mode),
   .user_prog_mode(user_prog_mode), .ram_we(ram_we), .branch(branch), .branch_addr(branch_addr));

// ==== testbench/fobe_host.sv ====
// host end of the boot serial link: sends and receives 8n1 frames
// assumes a pulled-up line and a host bit time given in clk cycles
`timescale 1ns/1ps
module fobe_host #(
   parameter int BIT_CYC = 41
) (
   // clock
   input wire logic clk,
   // serial lines
   output logic rxd,
   input wire logic txd
);
   // pull-up keeps the line high between frames
   initial rxd = 1'b1;
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] fr;
      fr = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk);
         rxd <= fr[i];
         repeat (BIT_CYC - 1) @(posedge clk);
      end
   endtask
   // samples on the falling edge so the device's updates have landed
   task automatic recv_byte(output logic [7:0] b, output logic stop_ok);
      @(negedge txd);
      repeat (BIT_CYC / 2) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(negedge clk);
         b[i] = txd;
      end
      repeat (BIT_CYC) @(negedge clk);
      stop_ok = txd;
      // let the device finish its stop bit before answering, or the reply start is missed
      repeat (BIT_CYC) @(negedge clk);
   endtask
endmodule

// ==== testbench/flash_overlay_and_boot_entry_tb.sv ====
// self-checking bench for overlay register, mode entry and serial boot loader
// assumes fobe_top, the host model and a 50 MHz clock; host bit time kept short
`timescale 1ns/1ps
module flash_overlay_and_boot_entry_tb;
   import fobe_pkg::*;
   // host bit time scaled far below a real host rate to keep the run short
   localparam int HB = 41;
   logic clk, rst, ce, standby, host_rxd, txd, mem_to_ram, flash_pe_lock, flash_pe_permit;
   logic boot_mode, user_prog_mode, ram_we, branch, ok;
   logic [4:0] mode_pins;
   logic [23:0] ram_addr, branch_addr;
   logic [7:0] ram_data, rb;
   logic [7:0] prog [3];
   logic [31:0] rd;
   fobe_wb_req_t wb_req;
   fobe_wb_rsp_t wb_rsp;
   fobe_mem_req_t cpu_req, mem_req;
   int fails = 0;
   int check_count = 0;
   int cyc_cnt = 0;
   int nload = 0;
   int nbr = 0;
   int seed;
   fobe_top dut_u (.clk(clk), .rst(rst), .ce(ce), .standby(standby), .wb_req(wb_req), .wb_rsp(wb_rsp),
      .pins({host_rxd, mode_pins}), .txd(txd), .cpu_req(cpu_req), .mem_req(mem_req),
      .mem_to_ram(mem_to_ram), .flash_pe_lock(flash_pe_lock), .flash_pe_permit(flash_pe_permit),
      .boot_mode(boot_mode), .user_prog_mode(user_prog_mode), .ram_we(ram_we), .ram_addr(ram_addr),
      .ram_data(ram_data), .branch(branch), .branch_addr(branch_addr));
   fobe_host #(.BIT_CYC(HB)) host_u (.clk(clk), .rxd(host_rxd), .txd(txd));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      if (fails == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         fails++;
         close_out();
      end
   end
   always @(negedge clk) begin
      if (ram_we === 1'b1) begin
         check(ram_addr, PROG_AREA_BASE + 24'(nload));
         check(ram_data, prog[nload]);
         nload++;
      end
      if (branch === 1'b1) begin
         check(branch_addr, PROG_AREA_BASE);
         nbr++;
      end
   end
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wb_req <= '{1'b1, 1'b1, we, a, 4'hf, d};
      do @(posedge clk); while (wb_rsp.ack !== 1'b1);
      rd = wb_rsp.dat;
      wb_req <= '0;
   endtask
   // cpu_req held at zero so the registered copy starts clean
   task automatic do_reset(input logic [4:0] mp);
      rst <= 1'b1;
      mode_pins <= mp;
      cpu_req <= '0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   function automatic logic [23:0] xlat(input logic [2:0] ov, input logic [23:0] a);
      if (ov[2] && a[23:10] == 14'h010 + {10'h0, ov[1:0], 2'h0}) return 24'hfff800 + 24'(a[9:0]);
      return a;
   endfunction
   task automatic mem(input logic [2:0] ov, input logic [23:0] a);
      logic w;
      w = 1'($random(seed));
      @(posedge clk);
      cpu_req <= '{1'b1, w, a};
      @(posedge clk);
      @(negedge clk);
      check(mem_req.addr, xlat(ov, a));
      check(mem_req.we, w);
      check(mem_to_ram, a[23:10] == 14'h3ffe || xlat(ov, a) != a);
   endtask
   task automatic boot_start();
      do_reset(5'h00);
      check({boot_mode, user_prog_mode, flash_pe_permit}, 3'b101);
      fork
         host_u.send_byte(8'h00);
         host_u.recv_byte(rb, ok);
      join
      check(rb, 8'h00);
      check(ok, 1'b1);
   endtask
   initial begin
      seed = 6876;
      rst = 1'b1;
      ce = 1'b1;
      standby = 1'b0;
      mode_pins = 5'h02;
      wb_req = '0;
      cpu_req = '0;
      do_reset(5'h02);
      check({boot_mode, user_prog_mode, flash_pe_permit, flash_pe_lock, txd}, 5'b01101);
      wb(1'b0, OFS_OVERLAY, 32'h0);
      check(rd, 32'h0);
      wb(1'b1, OFS_OVERLAY, 32'h0000_0007);
      standby <= 1'b1;
      wb(1'b0, OFS_OVERLAY, 32'h0);
      check(rd, 32'h7);
      check({flash_pe_lock, flash_pe_permit}, 2'b10);
      for (int ar = 0; ar < 4; ar++) begin
         wb(1'b1, OFS_OVERLAY, {29'h0, 1'b1, 2'(ar)});
         wb(1'b0, 8'h0c, 32'h0);
         check(rd, 32'h0);
         mem({1'b1, 2'(ar)}, 24'h004000 + {10'h0, 2'(ar), 12'h3ff});
         mem({1'b1, 2'(ar)}, 24'h004000 + {10'h0, 2'(ar), 12'h400});
         repeat (4) mem({1'b1, 2'(ar)}, 24'h004000 + 24'($random(seed) & 32'h3fff));
      end
      // a low clock enable must hold off the bus answer and keep the lock
      @(posedge clk);
      ce <= 1'b0;
      fork
         wb(1'b1, OFS_OVERLAY, 32'h0);
         begin
            repeat (4) @(posedge clk);
            check({wb_rsp.ack, flash_pe_lock}, 2'b01);
            ce <= 1'b1;
         end
      join
      wb(1'b0, OFS_STATUS, 32'h0);
      check(rd[3:0], 4'hd);
      repeat (4) mem(3'h0, 24'hfff800 + 24'($random(seed) & 32'h7ff));
      repeat (4) mem(3'h0, 24'h004000 + 24'($random(seed) & 32'h3fff));
      boot_start();
      wb(1'b0, OFS_PERIOD, 32'h0);
      check(rd, HB);
      for (int i = 0; i < 3; i++) prog[i] = 8'($random(seed));
      host_u.send_byte(8'h55);
      host_u.send_byte(8'h00);
      host_u.send_byte(8'h03);
      for (int i = 0; i < 3; i++) host_u.send_byte(prog[i]);
      repeat (HB) @(negedge clk);
      check(nload, 3);
      check(nbr, 1);
      wb(1'b0, OFS_STATUS, 32'h0);
      check({rd[31:16], rd[5:4]}, {16'h3, 2'b01});
      // restart in boot mode, then a bad key must leave the loader in its fail state with no new load or branch
      boot_start();
      host_u.send_byte(8'haa);
      repeat (HB) @(negedge clk);
      wb(1'b0, OFS_STATUS, 32'h0);
      check({rd[5:4], 8'(nload), 8'(nbr)}, {2'b10, 8'h3, 8'h1});
      close_out();
   end
endmodule
